// >>> verilog/vcfw_pkg.sv
// register map, field layout, bus codes and carrier types of the frame writer
package vcfw_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BURST = 8'h04;
  localparam logic [7:0] A_INT_EN = 8'h08;
  localparam logic [7:0] A_INT_STAT = 8'h0C;
  localparam logic [7:0] A_INT_CLR = 8'h10;
  localparam logic [7:0] A_B1_Y = 8'h14;
  localparam logic [7:0] A_B1_C = 8'h18;
  localparam logic [7:0] A_B2_Y = 8'h1C;
  localparam logic [7:0] A_B2_C = 8'h20;
  localparam logic [7:0] A_FSIZE = 8'h24;
  localparam logic [7:0] A_BSTAT = 8'h28;
  localparam logic [7:0] A_MISC = 8'h2C;
  localparam logic [7:0] A_STATE = 8'h30;
  // control and misc register fields
  localparam int CB_EN = 0;
  localparam int CB_UVFIRST = 1;
  localparam int CB_SENSOR = 2;
  localparam int CB_RAW = 4;
  localparam int CB_MODE = 8;
  localparam int CB_BIGEND = 11;
  localparam int CB_RAW10 = 12;
  localparam int MISC_BYPASS = 16;
  // work modes and burst types
  localparam logic [1:0] MODE_ONE = 2'h0;
  localparam logic [1:0] MODE_PP = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] BT_INCR8 = 2'h1;
  localparam logic [1:0] BT_INCR16 = 2'h2;
  localparam logic [4:0] LEN_INCR = 5'h04;
  localparam logic [4:0] LEN_INCR8 = 5'h08;
  localparam logic [4:0] LEN_INCR16 = 5'h10;
  // ahb codes
  localparam logic [2:0] HB_INCR = 3'h1;
  localparam logic [2:0] HB_INCR8 = 3'h5;
  localparam logic [2:0] HB_INCR16 = 3'h7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HT_IDLE = 2'h0;
  localparam logic [1:0] HT_NONSEQ = 2'h2;
  localparam logic [1:0] HT_SEQ = 2'h3;
  // interrupt bits and reset values
  localparam int IB_FRAME = 0;
  localparam int IB_OVR = 1;
  localparam int IB_BUSERR = 2;
  localparam int NUM_INT = 3;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // ccir656 timing code bytes and flag positions
  localparam logic [7:0] SYNC_FF = 8'hFF;
  localparam logic [7:0] SYNC_00 = 8'h00;
  localparam int XY_V = 5;
  localparam int XY_H = 4;

  typedef struct packed {
    logic [11:0] data;
    logic vsync;
    logic lvalid;
    logic pclk;
  } vcfw_pix_s;

  typedef enum logic [3:0] {
    F_IDLE = 4'h1, F_WAIT = 4'h2, F_CAP = 4'h4, F_FLUSH = 4'h8
  } vcfw_frame_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'h1, M_LUMA = 3'h2, M_CHROMA = 3'h4
  } vcfw_bus_e;
endpackage

// >>> verilog/vcfw_sync.sv
// two-stage synchroniser for the camera pins
module vcfw_sync
  import vcfw_pkg::*;
#(parameter int W = 15) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// >>> verilog/vcfw_top.sv
// video capture frame writer: pixel capture, packing, ahb write master, apb registers
// What this block and its host do
// R1 - host programs registers before starting capture
// R2 - write bursts are incr, incr8 or incr16
// R3 - host sets enable bit last
// R4 - control selects 656, work mode, byte order
// R5 - one-frame: host clears first buffer status
// R6 - one-frame: capture one frame, then stop
// R7 - two-buffer modes: host clears both statuses
// R8 - ping-pong switches to second buffer automatically
// R9 - unchanged buffer address gets overwritten
// R10 - ping-pong halts while both buffers ready
// R11 - continuous never halts unless disabled
// R12 - interrupt enable 0x1 flags every frame end
// R13 - accepts 10-bit, 12-bit raw and yuv
// R14 - host sets sensor and raw bits
// R15 - raw capture uses all three work modes
// R16 - yuv splits luma/chroma, raw single buffer
// R17 - four yuv or two raw pixels per word
// R18 - bypass routes camera pins to display
// R19 - last word written marks buffer ready
module vcfw_top
  import vcfw_pkg::*;
#(parameter int DEPTH = 16) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic [2:0] hburst_o,
  output logic [2:0] hsize_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o,
  input wire logic hready_i,
  input wire logic hresp_i,
  input wire logic pix_clk_i,
  input wire logic pix_vsync_i,
  input wire logic pix_lvalid_i,
  input wire logic [11:0] pix_data_i,
  output logic [7:0] disp_data_o,
  output logic disp_vsync_o,
  output logic disp_hsync_o,
  output logic disp_dclk_o,
  output logic irq_o
);
  localparam int IW = $clog2(DEPTH);
  localparam int WCW = IW + 1;

  logic [31:0] ctrl_reg, b1y_reg, b1c_reg, b2y_reg, b2c_reg, fsize_reg, misc_reg;
  logic [1:0] burst_reg, bstat_reg, p_mode;
  logic [NUM_INT-1:0] int_en_reg, int_stat_reg, ev;
  vcfw_frame_e fstate_reg;
  vcfw_bus_e bus_reg;
  vcfw_pix_s pin, pq;
  logic cur_reg, bsel, en, raw, sensor, allowed, fstart, act, samp, last, fdone, cap_go;
  logic pclk_d_reg, vs_d_reg, v656_reg, act656_reg, pe;
  logic [1:0] seq_reg;
  logic [7:0] byte_w;
  logic [15:0] pix16;
  logic [31:0] scnt_reg, tot, y_acc_reg, c_acc_reg, y_nx, c_nx, luma_ptr_reg, chroma_ptr_reg;
  logic [2:0] p_reg;
  logic st, st_ok, lum, clear, bstart, bdone, a_act_reg, d_act_reg, flushed;
  logic [31:0] y_mem [DEPTH];
  logic [31:0] c_mem [DEPTH];
  logic [IW-1:0] wr_idx_reg, rd_base_reg, ri;
  logic [WCW-1:0] wc_reg, beats_reg, a_cnt_reg, len, n;
  logic [2:0] code;
  logic acc, wr, hit;
  logic [31:0] rd_val;

  // control field decode
  assign en = ctrl_reg[CB_EN];
  assign raw = ctrl_reg[CB_RAW];
  assign sensor = ctrl_reg[CB_SENSOR];
  assign p_mode = ctrl_reg[CB_MODE+:2];
  assign bsel = (p_mode == MODE_ONE) ? 1'b0 : cur_reg; // see R6

  // camera pins are asynchronous to clock_i, so all of them share one synchroniser
  assign pin = '{data: pix_data_i, vsync: pix_vsync_i, lvalid: pix_lvalid_i, pclk: pix_clk_i};
  vcfw_sync #(.W($bits(vcfw_pix_s))) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(pin),
    .q_o(pq)
  );

  // pixel clock rising edge found by sampling; needs clock_i well above twice pclk
  assign pe = ce_i && pq.pclk && !pclk_d_reg;
  assign byte_w = pq.data[11:4];
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pclk_d_reg <= 1'b0;
      vs_d_reg <= 1'b0;
    end else if (ce_i) begin
      pclk_d_reg <= pq.pclk;
      if (pe) vs_d_reg <= pq.vsync;
    end
  end

  // ccir656 code tracker: ff 00 00 then the flag byte
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      seq_reg <= 2'h0;
      v656_reg <= 1'b1;
      act656_reg <= 1'b0;
    end else if (pe) begin
      if (seq_reg == 2'h3) begin
        seq_reg <= 2'h0;
        v656_reg <= byte_w[XY_V];
        act656_reg <= !byte_w[XY_V] && !byte_w[XY_H];
      end else if (byte_w == SYNC_FF) seq_reg <= 2'h1;
      else if (seq_reg != 2'h0 && byte_w == SYNC_00) seq_reg <= seq_reg + 2'h1;
      else seq_reg <= 2'h0;
    end
  end

  // frame start and active samples; 00 and ff never carry pixels in 656 framing
  assign fstart = sensor ? (pe && pq.vsync && !vs_d_reg) // see R4
                         : (pe && seq_reg == 2'h3 && !byte_w[XY_V] && v656_reg);
  assign act = sensor ? pq.lvalid
                      : (act656_reg && seq_reg != 2'h3 && byte_w != SYNC_FF && byte_w != SYNC_00);
  assign samp = pe && fstate_reg == F_CAP && act;
  assign tot = 32'(fsize_reg[15:0] * fsize_reg[31:16]);
  assign last = samp && (scnt_reg + 32'h1 == tot);
  assign flushed = wc_reg == '0 && bus_reg == M_IDLE;
  assign fdone = ce_i && fstate_reg == F_FLUSH && flushed;
  // ping-pong waits for a free buffer, continuous ignores status
  assign allowed = bus_reg == M_IDLE && (p_mode == MODE_CONT || !bstat_reg[bsel]); // see R10 see R11
  assign cap_go = ce_i && fstate_reg == F_WAIT && en && fstart && allowed;

  // frame sequencer
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fstate_reg <= F_IDLE;
      cur_reg <= 1'b0;
      scnt_reg <= 32'h0;
    end else if (ce_i) begin
      case (fstate_reg)
        F_IDLE: begin
          if (en) fstate_reg <= F_WAIT;
        end
        F_WAIT: begin
          if (!en) fstate_reg <= F_IDLE;
          else if (cap_go) begin
            fstate_reg <= F_CAP;
            scnt_reg <= 32'h0;
          end
        end
        F_CAP: begin
          if (!en) fstate_reg <= F_IDLE;
          else if (last) fstate_reg <= F_FLUSH;
          if (samp) scnt_reg <= scnt_reg + 32'h1;
        end
        F_FLUSH: begin
          if (flushed) begin
            if (p_mode == MODE_ONE) fstate_reg <= F_IDLE; // see R6
            else begin
              fstate_reg <= F_WAIT;
              cur_reg <= !cur_reg; // see R8 see R11 see R15
            end
          end
        end
        default: fstate_reg <= F_IDLE;
      endcase
    end
  end

  // sample packing: raw is two 16-bit halves, yuv is four bytes per plane
  assign pix16 = ctrl_reg[CB_RAW10] ? {6'h00, pq.data[11:2]} : {4'h0, pq.data}; // see R13
  assign lum = p_reg[0] == ctrl_reg[CB_UVFIRST];
  always_comb begin
    y_nx = y_acc_reg;
    c_nx = c_acc_reg;
    if (raw) begin
      if (!p_reg[0]) y_nx[15:0] = pix16;
      else if (ctrl_reg[CB_BIGEND]) y_nx = {y_acc_reg[15:0], pix16};
      else y_nx = {pix16, y_acc_reg[15:0]}; // see R17
    end else if (lum) y_nx[8*p_reg[2:1]+:8] = byte_w;
    else c_nx[8*p_reg[2:1]+:8] = byte_w; // see R16
  end
  assign st = samp && (raw ? p_reg[0] : p_reg == 3'h7); // see R17

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      p_reg <= 3'h0;
      y_acc_reg <= 32'h0;
      c_acc_reg <= 32'h0;
    end else if (ce_i) begin
      if (cap_go) p_reg <= 3'h0;
      else if (samp) begin
        p_reg <= p_reg + 3'h1;
        y_acc_reg <= y_nx;
        c_acc_reg <= c_nx;
      end
    end
  end

  // word store, a ring that the burst master drains; a full ring drops words
  assign st_ok = st && wc_reg != WCW'(DEPTH);
  assign clear = fstate_reg == F_IDLE && bus_reg == M_IDLE;
  always_ff @(posedge clock_i) begin
    if (ce_i && st_ok) begin
      y_mem[wr_idx_reg] <= y_nx;
      c_mem[wr_idx_reg] <= c_nx;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wc_reg <= '0;
      wr_idx_reg <= '0;
      rd_base_reg <= '0;
    end else if (ce_i) begin
      if (st_ok) wr_idx_reg <= wr_idx_reg + IW'(1);
      if (clear) begin
        wc_reg <= '0;
        rd_base_reg <= wr_idx_reg;
      end else begin
        wc_reg <= wc_reg + WCW'(st_ok) - (bdone ? beats_reg : '0);
        if (bdone) rd_base_reg <= rd_base_reg + beats_reg[IW-1:0];
      end
    end
  end

  // burst length from the burst type; the frame tail goes out as a short incr
  always_comb begin
    case (burst_reg)
      BT_INCR8: begin
        len = LEN_INCR8;
        code = HB_INCR8;
      end
      BT_INCR16: begin
        len = LEN_INCR16;
        code = HB_INCR16;
      end
      default: begin
        len = LEN_INCR;
        code = HB_INCR;
      end
    endcase
  end
  assign n = (wc_reg >= len) ? len : wc_reg;
  assign bstart = ce_i && bus_reg == M_IDLE && (wc_reg >= len ||
                  (fstate_reg == F_FLUSH && wc_reg != '0));
  assign bdone = ce_i && hready_i && !a_act_reg && d_act_reg && (bus_reg == M_CHROMA || raw);
  assign ri = rd_base_reg + a_cnt_reg[IW-1:0];

  // ahb write master: address phase of beat k overlaps data phase of beat k-1
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      bus_reg <= M_IDLE;
      a_act_reg <= 1'b0;
      d_act_reg <= 1'b0;
      a_cnt_reg <= '0;
      beats_reg <= '0;
      haddr_o <= 32'h0;
      htrans_o <= HT_IDLE;
      hburst_o <= HB_INCR;
      hwdata_o <= 32'h0;
      luma_ptr_reg <= 32'h0;
      chroma_ptr_reg <= 32'h0;
    end else if (ce_i) begin
      if (cap_go) begin
        // buffer address is taken at each frame start, so a stale one is rewritten
        luma_ptr_reg <= bsel ? b2y_reg : b1y_reg; // see R9
        chroma_ptr_reg <= bsel ? b2c_reg : b1c_reg;
      end
      case (bus_reg)
        M_IDLE: begin
          if (bstart) begin
            bus_reg <= M_LUMA;
            a_act_reg <= 1'b1;
            a_cnt_reg <= '0;
            beats_reg <= n;
            hburst_o <= (wc_reg >= len) ? code : HB_INCR; // see R2
            haddr_o <= luma_ptr_reg;
            htrans_o <= HT_NONSEQ;
          end
        end
        M_LUMA, M_CHROMA: begin
          if (hready_i) begin
            if (a_act_reg) begin
              hwdata_o <= (bus_reg == M_CHROMA) ? c_mem[ri] : y_mem[ri];
              d_act_reg <= 1'b1;
              a_cnt_reg <= a_cnt_reg + WCW'(1);
              haddr_o <= haddr_o + 32'h4;
              if (a_cnt_reg + WCW'(1) == beats_reg) begin
                a_act_reg <= 1'b0;
                htrans_o <= HT_IDLE;
              end else htrans_o <= HT_SEQ;
            end else if (d_act_reg) begin
              d_act_reg <= 1'b0;
              if (bus_reg == M_LUMA) begin
                luma_ptr_reg <= luma_ptr_reg + 32'({beats_reg, 2'b00});
                if (raw) bus_reg <= M_IDLE; // see R16
                else begin
                  bus_reg <= M_CHROMA;
                  a_act_reg <= 1'b1;
                  a_cnt_reg <= '0;
                  haddr_o <= chroma_ptr_reg;
                  htrans_o <= HT_NONSEQ;
                end
              end else begin
                chroma_ptr_reg <= chroma_ptr_reg + 32'({beats_reg, 2'b00});
                bus_reg <= M_IDLE;
              end
            end
          end
        end
        default: bus_reg <= M_IDLE;
      endcase
    end
  end
  assign hsize_o = HSIZE_WORD;
  assign hwrite_o = 1'b1;

  // apb slave: zero wait states, read data captured in the setup cycle
  assign acc = psel_i && penable_i;
  assign wr = ce_i && acc && pwrite_i;
  assign pready_o = 1'b1;
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      A_CTRL: rd_val = ctrl_reg;
      A_BURST: rd_val = {30'h0, burst_reg};
      A_INT_EN: rd_val = {29'h0, int_en_reg};
      A_INT_STAT: rd_val = {29'h0, int_stat_reg};
      A_INT_CLR: rd_val = 32'h0;
      A_B1_Y: rd_val = b1y_reg;
      A_B1_C: rd_val = b1c_reg;
      A_B2_Y: rd_val = b2y_reg;
      A_B2_C: rd_val = b2c_reg;
      A_FSIZE: rd_val = fsize_reg;
      A_BSTAT: rd_val = {30'h0, bstat_reg};
      A_MISC: rd_val = misc_reg;
      A_STATE: rd_val = {19'h0, wc_reg[4:0], bus_reg, cur_reg, fstate_reg};
      default: begin
        rd_val = 32'h0;
        hit = 1'b0;
      end
    endcase
  end
  assign pslverr_o = acc && !hit;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) prdata_o <= 32'h0;
    else if (ce_i && psel_i && !penable_i) prdata_o <= pwrite_i ? 32'h0 : rd_val;
  end

  // configuration registers; a one-frame capture drops its own enable when done
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ctrl_reg <= REG_RST;
      burst_reg <= REG_RST[1:0];
      int_en_reg <= REG_RST[NUM_INT-1:0];
      b1y_reg <= REG_RST;
      b1c_reg <= REG_RST;
      b2y_reg <= REG_RST;
      b2c_reg <= REG_RST;
      fsize_reg <= REG_RST;
      misc_reg <= REG_RST;
    end else if (ce_i) begin
      if (wr && paddr_i == A_CTRL) ctrl_reg <= pwdata_i; // see R4
      else if (fdone && p_mode == MODE_ONE) ctrl_reg[CB_EN] <= 1'b0; // see R6
      if (wr && paddr_i == A_BURST) burst_reg <= pwdata_i[1:0];
      if (wr && paddr_i == A_INT_EN) int_en_reg <= pwdata_i[NUM_INT-1:0];
      if (wr && paddr_i == A_B1_Y) b1y_reg <= pwdata_i;
      if (wr && paddr_i == A_B1_C) b1c_reg <= pwdata_i;
      if (wr && paddr_i == A_B2_Y) b2y_reg <= pwdata_i;
      if (wr && paddr_i == A_B2_C) b2c_reg <= pwdata_i;
      if (wr && paddr_i == A_FSIZE) fsize_reg <= pwdata_i;
      if (wr && paddr_i == A_MISC) misc_reg <= pwdata_i;
    end
  end

  // sticky status bits: a hardware set in the clearing cycle wins
  assign ev = {d_act_reg && hready_i && hresp_i, st && !st_ok, fstate_reg == F_FLUSH && flushed};
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      bstat_reg <= 2'h0;
      int_stat_reg <= '0;
    end else if (ce_i) begin
      bstat_reg <= (bstat_reg & ~((wr && paddr_i == A_BSTAT) ? pwdata_i[1:0] : 2'h0))
                   | (fdone ? (2'h1 << bsel) : 2'h0); // see R19
      int_stat_reg <= (int_stat_reg & ~((wr && paddr_i == A_INT_CLR) ? pwdata_i[NUM_INT-1:0] : '0))
                      | ev; // see R12
    end
  end
  assign irq_o = |(int_stat_reg & int_en_reg); // see R12

  // display bypass from the synchronised pins; three clock_i cycles of delay
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      disp_data_o <= 8'h00;
      disp_vsync_o <= 1'b0;
      disp_hsync_o <= 1'b0;
      disp_dclk_o <= 1'b0;
    end else if (ce_i) begin
      disp_data_o <= misc_reg[MISC_BYPASS] ? pq.data[11:4] : 8'h00; // see R18
      disp_vsync_o <= misc_reg[MISC_BYPASS] && pq.vsync;
      disp_hsync_o <= misc_reg[MISC_BYPASS] && pq.lvalid;
      disp_dclk_o <= misc_reg[MISC_BYPASS] && pq.pclk;
    end
  end

  // checks
  sequence s_frame_done;
    fdone;
  endsequence
  sequence s_one_done;
    fdone && p_mode == MODE_ONE;
  endsequence
  property p_burst_code;
    @(posedge clock_i) disable iff (!rstn_i)
      (bstart && wc_reg >= len) |=> (hburst_o == code && htrans_o == HT_NONSEQ && beats_reg == len);
  endproperty
  a_burst_code: assert property (p_burst_code) else $error("burst type not followed"); // see R2
  property p_one_stop;
    @(posedge clock_i) disable iff (!rstn_i)
      s_one_done |=> (!en && fstate_reg == F_IDLE);
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("one-frame mode did not stop"); // see R6
  property p_pp_halt;
    @(posedge clock_i) disable iff (!rstn_i)
      (fstate_reg == F_WAIT && p_mode == MODE_PP && bstat_reg == 2'h3) |=> fstate_reg != F_CAP;
  endproperty
  a_pp_halt: assert property (p_pp_halt) else $error("ping-pong captured into full buffers"); // see R10
  property p_cont_run;
    @(posedge clock_i) disable iff (!rstn_i)
      (p_mode == MODE_CONT && fstate_reg == F_WAIT && en && fstart && ce_i && bus_reg == M_IDLE)
      |=> fstate_reg == F_CAP;
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("continuous mode halted"); // see R11
  property p_frame_irq;
    @(posedge clock_i) disable iff (!rstn_i)
      (s_frame_done ##0 int_en_reg[IB_FRAME]) |=> irq_o;
  endproperty
  a_frame_irq: assert property (p_frame_irq) else $error("no frame interrupt"); // see R12
  property p_ready_mark;
    @(posedge clock_i) disable iff (!rstn_i)
      s_frame_done |=> bstat_reg[$past(bsel)];
  endproperty
  a_ready_mark: assert property (p_ready_mark) else $error("buffer not marked ready"); // see R19
  property p_raw_single;
    @(posedge clock_i) disable iff (!rstn_i)
      raw |-> bus_reg != M_CHROMA;
  endproperty
  a_raw_single: assert property (p_raw_single) else $error("raw data sent to chroma buffer"); // see R16
  property p_raw_pack;
    @(posedge clock_i) disable iff (!rstn_i)
      (st && raw && !ctrl_reg[CB_BIGEND]) |-> y_nx == {pix16, y_acc_reg[15:0]};
  endproperty
  a_raw_pack: assert property (p_raw_pack) else $error("raw halves misplaced"); // see R17
  property p_raw10;
    @(posedge clock_i) disable iff (!rstn_i)
      (samp && raw && ctrl_reg[CB_RAW10]) |-> pix16[15:10] == 6'h00 && pix16[9:0] == pq.data[11:2];
  endproperty
  a_raw10: assert property (p_raw10) else $error("raw10 sample misaligned"); // see R13
  property p_stale_addr;
    @(posedge clock_i) disable iff (!rstn_i)
      cap_go |=> luma_ptr_reg == ($past(bsel) ? $past(b2y_reg) : $past(b1y_reg));
  endproperty
  a_stale_addr: assert property (p_stale_addr) else $error("buffer address not reloaded"); // see R9
  property p_bypass;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && misc_reg[MISC_BYPASS]) |=> disp_data_o == $past(pq.data[11:4]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass data wrong"); // see R18
endmodule

// >>> sim/vcfw_cam.sv
// camera source model: sensor-style frames, pixel clock only runs inside a frame
module vcfw_cam (
  output logic pclk_o,
  output logic vsync_o,
  output logic lvalid_o,
  output logic [11:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pclk_o = 1'b0;
    vsync_o = 1'b0;
    lvalid_o = 1'b0;
    data_o = 12'h000;
  end
  // one frame of n samples; 80 ns pixel period, pins stable across each rising pclk
  task automatic frame(input int n, input logic [11:0] base, input logic [11:0] step);
    for (int j = 0; j < 2; j++) begin
      vsync_o <= j[0];
      #40 pclk_o <= 1'b1;
      #40 pclk_o <= 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      lvalid_o <= 1'b1;
      data_o <= base + 12'(i) * step;
      #40 pclk_o <= 1'b1;
      #40 pclk_o <= 1'b0;
    end
    // released data bus shows the inverse, so a stale value never passes for fresh
    lvalid_o <= 1'b0;
    vsync_o <= 1'b0;
    data_o <= ~data_o;
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the video capture frame writer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vcfw_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, haddr_o, hwdata_o, rv, dadr;
  logic pready_o, pslverr_o, hwrite_o, irq_o, perr, pclk, vs, lv, dvs, dhs, dck;
  logic dph = 1'b0;
  logic [1:0] htrans_o;
  logic [2:0] hburst_o, hsize_o, fb;
  logic [11:0] pdat;
  logic [7:0] ddat;
  logic [31:0] mem [logic [31:0]];
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clock_i = ~clock_i;
  vcfw_cam cam_u (.pclk_o(pclk), .vsync_o(vs), .lvalid_o(lv), .data_o(pdat));
  vcfw_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .haddr_o(haddr_o), .htrans_o(htrans_o), .hburst_o(hburst_o), .hsize_o(hsize_o),
    .hwrite_o(hwrite_o), .hwdata_o(hwdata_o), .hready_i(1'b1), .hresp_i(1'b0), .pix_clk_i(pclk),
    .pix_vsync_i(vs), .pix_lvalid_i(lv), .pix_data_i(pdat), .disp_data_o(ddat), .disp_vsync_o(dvs),
    .disp_hsync_o(dhs), .disp_dclk_o(dck), .irq_o(irq_o));
  // memory stand-in: always ready, stores each data phase; also the run's watchdog
  always @(posedge clock_i) begin
    if (dph) mem[dadr] = hwdata_o;
    if (htrans_o === HT_NONSEQ) fb <= hburst_o;
    dph <= htrans_o[1] & rstn_i;
    dadr <= haddr_o;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // apb transfer; the master holds everything until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rv = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(rv, e, what);
  endtask
  // luma (off 0) or chroma (off 1) word w of a frame whose byte k is b+k
  function automatic logic [31:0] yw(input logic [7:0] b, input int w, input int off);
    for (int j = 0; j < 4; j++) yw[8*j +: 8] = b + 8'(8*w + off + 2*j);
  endfunction
  // host setup in the recommended order, enable written last
  task automatic cfg(input logic [31:0] ctrl, input logic [1:0] bt, input logic [31:0] fs);
    wr(A_BURST, {30'h0, bt});
    wr(A_INT_EN, 32'h1);
    wr(A_CTRL, ctrl);
    wr(A_B1_Y, 32'h0000_1000);
    wr(A_B1_C, 32'h0000_2000);
    wr(A_B2_Y, 32'h0000_3000);
    wr(A_B2_C, 32'h0000_4000);
    wr(A_FSIZE, fs);
    wr(A_BSTAT, 32'h3);
    wr(A_INT_CLR, 32'h7);
    wr(A_CTRL, ctrl | 32'h1);
  endtask
  // one frame from the camera, then wait boundedly for the frame-done interrupt
  task automatic grab(input int n, input logic [11:0] b, input logic [11:0] s, input logic ie);
    cam_u.frame(n, b, s);
    @(posedge clock_i);
    for (int k = 0; k < 400 && irq_o !== 1'b1; k++) @(posedge clock_i);
    chk({31'h0, irq_o}, {31'h0, ie}, "frame irq");
    wr(A_INT_CLR, 32'h1);
  endtask
  task automatic t_reset;
    rd(A_CTRL, REG_RST, "ctrl reset");
    rd(A_BSTAT, REG_RST, "status reset");
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, perr}, 32'h1, "unmapped refused");
    $display("test reset done");
  endtask
  task automatic t_one;
    cfg(32'h0000_0004, 2'h0, {16'h0001, 16'h0020});
    grab(32, 12'h100, 12'h010, 1'b1);
    for (int w = 0; w < 4; w++) begin
      chk(mem[32'h1000 + 4*w], yw(8'h10, w, 0), "luma word");
      chk(mem[32'h2000 + 4*w], yw(8'h10, w, 1), "chroma word");
    end
    chk({29'h0, fb}, {29'h0, HB_INCR}, "burst type");
    rd(A_BSTAT, 32'h1, "first ready");
    rd(A_CTRL, 32'h0000_0004, "self stop");
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    $display("test one-frame done");
  endtask
  // ping-pong halts with both buffers ready; continuous overwrites the first buffer, chroma first
  task automatic t_two(input logic [1:0] mode);
    cfg({22'h0, mode, 6'h01, mode[1], 1'b0}, BT_INCR8, {16'h0001, 16'h0040});
    grab(64, 12'h200, 12'h010, 1'b1);
    chk({29'h0, fb}, {29'h0, HB_INCR8}, "burst type");
    chk(mem[32'h101C], yw(8'h20, 7, mode[1]), "frame one");
    grab(64, 12'h600, 12'h010, 1'b1);
    chk(mem[32'h301C], yw(8'h60, 7, mode[1]), "frame two");
    rd(A_BSTAT, 32'h3, "both ready");
    grab(64, 12'hA00, 12'h010, mode == MODE_CONT);
    chk(mem[32'h101C], mode == MODE_CONT ? yw(8'hA0, 7, 1) : yw(8'h20, 7, 0), "frame three");
    wr(A_CTRL, 32'h0);
    $display("test two-buffer mode %0d done", mode);
  endtask
  // raw word of pixels a then b: zero-extended halves, raw10 keeps the top ten pin bits
  function automatic logic [31:0] rw(input logic [11:0] a, input logic [11:0] b, input logic be, input logic r10);
    logic [15:0] p0, p1;
    p0 = r10 ? {6'h00, a[11:2]} : {4'h0, a};
    p1 = r10 ? {6'h00, b[11:2]} : {4'h0, b};
    rw = be ? {p0, p1} : {p1, p0};
  endfunction
  task automatic t_raw(input logic be, input logic r10);
    cfg({19'h0, r10, be, 11'h014}, 2'h0, {16'h0001, 16'h0004});
    grab(4, 12'h123, 12'h111, 1'b1);
    chk(mem[32'h1000], rw(12'h123, 12'h234, be, r10), "raw word");
    chk(mem[32'h1004], rw(12'h345, 12'h456, be, r10), "raw word");
    $display("test raw endian %0d raw10 %0d done", be, r10);
  endtask
  task automatic t_bypass;
    wr(A_MISC, 32'h0001_0000);
    repeat (8) @(posedge clock_i);
    chk({24'h0, ddat}, {24'h0, pdat[11:4]}, "bypass data");
    chk({30'h0, dvs, dhs}, {30'h0, vs, lv}, "bypass syncs");
    // a one-sample frame makes every bypassed pin toggle
    fork
      cam_u.frame(1, 12'h5A0, 12'h000);
    join_none
    for (int k = 0; k < 40 && !(dck === 1'b1 && dhs === 1'b1); k++) @(posedge clock_i);
    chk({29'h0, dck, dvs, dhs}, 32'h7, "bypass pins");
    chk({24'h0, ddat}, 32'h5A, "bypass frame data");
    repeat (30) @(posedge clock_i);
    wr(A_MISC, 32'h0);
    repeat (4) @(posedge clock_i);
    chk({21'h0, ddat, dck, dvs, dhs}, 32'h0, "bypass off");
    $display("test bypass done");
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset();
    t_one();
    t_two(MODE_PP);
    t_two(MODE_CONT);
    t_raw(1'b0, 1'b0);
    t_raw(1'b1, 1'b0);
    t_raw(1'b0, 1'b1);
    t_bypass();
    complete_run();
  end
endmodule
